// file: rtl/svc_term_pkg.sv
// Constants shared by the compressor service terminal block.
// Assumes a 25 MHz system clock and a 9600 8N1 serial link.
package svc_term_pkg;
  localparam int CLK_HZ = 25000000;            // System clock rate
  localparam int BAUD = 9600;                  // Link rate
  localparam int BIT_CYCLES = CLK_HZ / BAUD;   // Cycles per bit, 2604
  localparam int HALF_BIT = BIT_CYCLES / 2;    // Mid-bit sample point
  localparam int DATA_BITS = 8;                // Data bits per frame
  localparam logic [7:0] CHAR_CR = 8'h0d;      // Line end
  localparam logic [7:0] CHAR_LF = 8'h0a;      // Line feed
  localparam logic [7:0] CHAR_SP = 8'h20;      // Space
  localparam logic [7:0] CHAR_M = 8'h6d;       // Menu letter
  localparam logic [7:0] CHAR_A = 8'h61;       // First command letter
  localparam logic [7:0] CHAR_I = 8'h69;       // Last command letter
  localparam logic [7:0] CASE_BIT = 8'h20;     // Upper to lower case
  localparam logic [15:0] ADS_LIFE_NEW = 16'h7530; // 30000 hours
  localparam int HIST_DEPTH = 20;              // Fault history entries
  localparam int LOG_DEPTH = 16;               // Raw log words
  localparam int RESTART_MAX = 5;              // Automatic restart tries
  localparam int RESTART_MIN = 20;             // Minutes between tries
  localparam int LOCKOUT_MIN = 19;             // Mode 2 ignore window
  localparam int NUM_FAULTS = 7;               // Fault sources
  localparam logic [7:0] FW_VERSION = 8'h17;   // Arbitrary version code
endpackage

// file: rtl/uart_tx_serial.sv
// Serial transmitter, 8N1 at the link rate.
// Assumes one clock; start pulse only when ready.
`timescale 1ns/1ps
`default_nettype none
module uart_tx_serial
  import svc_term_pkg::*;
#(
  parameter int BAUD_CYCLES = BIT_CYCLES // Cycles per serial bit
)(
  input wire logic clk,          // System clock
  input wire logic sys_rst,      // Synchronous reset
  input wire logic start,        // Send request pulse
  input wire logic [7:0] data,   // Byte to send
  output logic ready,            // Idle and can take a byte
  output logic txd               // Serial line out
);
  logic [9:0] shift;             // Frame bits remaining
  logic [3:0] bitsLeft;          // Bits still to send
  logic [11:0] baudCount;        // Bit timer

  assign ready = (bitsLeft == 4'h0);

  // Shift frame out with no flow control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift <= 10'h3ff;
      bitsLeft <= 4'h0;
      baudCount <= 12'h000;
      txd <= 1'b1;
    end else if (ready && start) begin
      shift <= {1'b1, data, 1'b0};
      bitsLeft <= 4'ha;
      baudCount <= 12'h000;
    end else if (!ready) begin
      if (baudCount == 12'h000) begin
        txd <= shift[0];
        shift <= {1'b1, shift[9:1]};
        baudCount <= 12'(BAUD_CYCLES - 1);
      end else begin
        baudCount <= baudCount - 12'h001;
        if (baudCount == 12'h001) begin
          bitsLeft <= bitsLeft - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/compressor_service_terminal.sv
// Service terminal command interpreter for the compressor controller.
// Assumes sensor words arrive synchronous, serial input from a pin.
`timescale 1ns/1ps
`default_nettype none
module compressor_service_terminal
  import svc_term_pkg::*;
#(
  parameter int MINUTE_CYCLES = 1500000000, // Cycles per minute
  parameter int BAUD_CYCLES = BIT_CYCLES // Cycles per serial bit
)(
  input wire logic clk,                  // System clock
  input wire logic sys_rst,              // Synchronous reset
  input wire logic rxd,                  // Serial line in
  output logic txd,                      // Serial line out
  input wire logic configMode2,          // High selects mode 2
  input wire logic remoteClear,          // Remote clear pin, async
  input wire logic upButton,             // Display up, async
  input wire logic downButton,           // Display down, async
  input wire logic onButton,             // On button, async
  input wire logic [NUM_FAULTS-1:0] faultIn, // Fault detect pulses
  input wire logic heliumCool,           // Helium temp below cut-off
  input wire logic [15:0] returnPressBar,  // Pressure, bar
  input wire logic [15:0] returnPressPsig, // Pressure, psig
  input wire logic [15:0] heliumTemp,    // Helium temperature
  input wire logic [15:0] waterTemp,     // Water temperature
  input wire logic hourTick,             // One run hour elapsed
  output logic [NUM_FAULTS-1:0] faultLatched, // Diagnostic outputs
  output logic compressorOn              // Run command
);
  localparam int HELIUM_FAULT = 0;       // Helium over-temp source

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } rx_state_type;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001, TX_SEND = 3'b010, TX_WAIT = 3'b100
  } tx_state_type;

  // Pin synchronisers
  logic [1:0] rxSync, clrSync, upSync, downSync, onSync;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxSync <= 2'b11;
      clrSync <= 2'b00;
      upSync <= 2'b00;
      downSync <= 2'b00;
      onSync <= 2'b00;
    end else begin
      rxSync <= {rxSync[0], rxd};
      clrSync <= {clrSync[0], remoteClear};
      upSync <= {upSync[0], upButton};
      downSync <= {downSync[0], downButton};
      onSync <= {onSync[0], onButton};
    end
  end
  logic rxLine;
  assign rxLine = rxSync[1];

  // Receiver
  rx_state_type rxState;
  logic [11:0] rxCount;     // Bit timer
  logic [2:0] rxBit;        // Data bit index
  logic [7:0] rxShift;      // Assembled byte
  logic rxValid;            // Byte received pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState <= RX_IDLE;
      rxCount <= 12'h000;
      rxBit <= 3'h0;
      rxShift <= 8'h00;
      rxValid <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      case (rxState)
        RX_IDLE: begin
          if (!rxLine) begin
            rxState <= RX_START;
            rxCount <= 12'(BAUD_CYCLES / 2);
          end
        end
        RX_START: begin
          if (rxCount == 12'h000) begin
            rxState <= rxLine ? RX_IDLE : RX_DATA; // Glitch rejects
            rxCount <= 12'(BAUD_CYCLES - 1);
            rxBit <= 3'h0;
          end else rxCount <= rxCount - 12'h001;
        end
        RX_DATA: begin
          if (rxCount == 12'h000) begin
            rxShift <= {rxLine, rxShift[7:1]};
            rxCount <= 12'(BAUD_CYCLES - 1);
            if (rxBit == 3'h7) rxState <= RX_STOP;
            rxBit <= rxBit + 3'h1;
          end else rxCount <= rxCount - 12'h001;
        end
        RX_STOP: begin
          if (rxCount == 12'h000) begin
            rxState <= RX_IDLE;
            rxValid <= rxLine; // Framing error drops byte
          end else rxCount <= rxCount - 12'h001;
        end
        default: rxState <= RX_IDLE;
      endcase
    end
  end

  // Case-fold and classify a character
  function automatic logic isCommand(input logic [7:0] c);
    isCommand = (c == CHAR_M) || (c >= CHAR_A && c <= CHAR_I);
  endfunction
  logic [7:0] rxLower;
  assign rxLower = (rxShift >= 8'h41 && rxShift <= 8'h5a) ? (rxShift | CASE_BIT) : rxShift;

  // Pending command letter, fired by carriage return
  logic [7:0] pending;     // Held letter, zero when none
  logic cmdFire;           // Command execute pulse
  logic [7:0] cmdLetter;   // Letter executed
  logic txBusy;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pending <= 8'h00;
      cmdFire <= 1'b0;
      cmdLetter <= 8'h00;
    end else begin
      cmdFire <= 1'b0;
      if (rxValid) begin
        if (rxShift == CHAR_CR) begin
          if (pending != 8'h00 && !txBusy) begin
            cmdFire <= 1'b1;
            cmdLetter <= pending;
          end
          pending <= 8'h00;
        end else if (isCommand(rxLower)) begin
          pending <= rxLower;
        end else begin
          pending <= 8'h00;
        end
      end
    end
  end

  // Fault latches and clearing
  logic clearReq;   // Qualified clear pulse
  logic clrPrev, bothPrev;
  logic bothPressed;
  assign bothPressed = upSync[1] && downSync[1];
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clrPrev <= 1'b0;
      bothPrev <= 1'b0;
      clearReq <= 1'b0;
    end else begin
      clrPrev <= clrSync[1];
      bothPrev <= bothPressed;
      // Remote only in mode 2, buttons or remote in mode 1
      clearReq <= configMode2 ? (clrSync[1] && !clrPrev)
                              : ((bothPressed && !bothPrev) ||
                                 (clrSync[1] && !clrPrev));
    end
  end

  logic [31:0] minCount;    // Minute prescaler
  logic [4:0] minutes;      // Minutes since helium trip
  logic [2:0] restarts;     // Automatic restarts used
  logic minPulse;
  always_ff @(posedge clk) begin
    if (sys_rst || !faultLatched[HELIUM_FAULT]) begin
      minCount <= 32'h0;
      minPulse <= 1'b0;
    end else begin
      minPulse <= (minCount == 32'(MINUTE_CYCLES - 1));
      minCount <= (minCount == 32'(MINUTE_CYCLES - 1)) ? 32'h0 : minCount + 32'h1;
    end
  end

  // Auto reset allowed only from minute RESTART_MIN on, in mode 2 as in mode 1
  logic autoClear;
  assign autoClear = faultLatched[HELIUM_FAULT] && heliumCool &&
                     (restarts < 3'(RESTART_MAX)) &&
                     (configMode2 ? (minutes >= 5'(LOCKOUT_MIN))
                                  : (minutes >= 5'(RESTART_MIN))) &&
                     (minutes >= 5'(RESTART_MIN));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      minutes <= 5'h00;
      restarts <= 3'h0;
    end else if (clearReq) begin
      minutes <= 5'h00;
      restarts <= 3'h0;
    end else if (autoClear) begin
      minutes <= 5'h00;
      restarts <= restarts + 3'h1;
    end else if (minPulse && minutes != 5'h1f) begin
      minutes <= minutes + 5'h01;
    end
  end

  // Sticky faults; new event wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) faultLatched <= '0;
    else if (clearReq) faultLatched <= faultIn;
    else if (autoClear) faultLatched <= faultIn | (faultLatched & ~NUM_FAULTS'(1));
    else faultLatched <= faultLatched | faultIn;
  end

  // Run command
  logic onPrev;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      compressorOn <= 1'b0;
      onPrev <= 1'b0;
    end else begin
      onPrev <= onSync[1];
      // Auto restart only if no other fault stands or arrives
      if (autoClear) compressorOn <= ~|(faultIn | (faultLatched & ~NUM_FAULTS'(1)));
      else if (|faultLatched) compressorOn <= 1'b0;
      else if (onSync[1] && !onPrev && heliumCool) compressorOn <= 1'b1;
    end
  end

  // Hour counters and adsorber life
  logic [15:0] serviceHours, masterHours, adsLife;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      serviceHours <= 16'h0000;
      masterHours <= 16'h0000;
    end else if (hourTick && compressorOn) begin
      serviceHours <= serviceHours + 16'h0001;
      masterHours <= masterHours + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) adsLife <= ADS_LIFE_NEW;
    else if (cmdFire && cmdLetter == 8'h67) adsLife <= ADS_LIFE_NEW;
    else if (hourTick && compressorOn && adsLife != 16'h0000) adsLife <= adsLife - 16'h0001;
  end

  // Circular fault history
  logic [2:0] histCode [HIST_DEPTH];
  logic [15:0] histTime [HIST_DEPTH];
  logic [7:0] histSeq [HIST_DEPTH];
  logic [4:0] histWr;
  logic [7:0] seqNext;
  logic [2:0] newCode;
  logic newFault;
  always_comb begin
    newFault = 1'b0;
    newCode = 3'h0;
    for (int k = NUM_FAULTS - 1; k >= 0; k--) begin
      if (faultIn[k] && !faultLatched[k]) begin
        newFault = 1'b1;
        newCode = 3'(k);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      histWr <= 5'h00;
      seqNext <= 8'h01;
      for (int k = 0; k < HIST_DEPTH; k++) begin
        histCode[k] <= 3'h0;
        histTime[k] <= 16'h0000;
        histSeq[k] <= 8'h00;
      end
    end else if (newFault) begin
      histCode[histWr] <= newCode;
      histTime[histWr] <= serviceHours;
      histSeq[histWr] <= seqNext;
      seqNext <= seqNext + 8'h01;
      histWr <= (histWr == 5'(HIST_DEPTH - 1)) ? 5'h00 : histWr + 5'h01;
    end
  end

  // Reply formatter: one record per line, hex fields
  tx_state_type txState;
  logic [4:0] recIdx;     // Record (line) number
  logic [3:0] charIdx;    // Character in line
  logic [7:0] txChar;
  logic txStart, txReady;
  logic [4:0] recLast;
  logic [15:0] fieldA, fieldB;
  logic [7:0] tag;
  function automatic logic [7:0] hexChar(input logic [3:0] n);
    hexChar = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
  endfunction
  always_comb begin
    tag = cmdLetter;
    fieldA = 16'h0000;
    fieldB = 16'h0000;
    recLast = 5'h00;
    case (cmdLetter)
      8'h61: fieldA = {8'h00, FW_VERSION};
      8'h62: begin fieldA = {15'h0, configMode2}; fieldB = {8'h00, compressorOn, faultLatched}; end
      8'h63: begin fieldA = serviceHours; fieldB = masterHours; end
      8'h64: begin fieldA = returnPressBar; fieldB = returnPressPsig; end
      8'h65: begin fieldA = heliumTemp; fieldB = waterTemp; end
      8'h66, 8'h67: fieldA = adsLife;
      8'h68: begin
        recLast = 5'(HIST_DEPTH - 1);
        fieldA = {histSeq[recIdx], 5'h00, histCode[recIdx]};
        fieldB = histTime[recIdx];
      end
      8'h69: begin
        recLast = 5'(LOG_DEPTH - 1);
        fieldA = histTime[recIdx];
        fieldB = {13'h0, histCode[recIdx]};
      end
      default: begin tag = CHAR_M; fieldA = 16'h0069; end
    endcase
  end
  // Line: tag, sp, 4 hex, sp, 4 hex, CR, LF
  always_comb begin
    case (charIdx)
      4'h0: txChar = tag;
      4'h1, 4'h6: txChar = CHAR_SP;
      4'h2: txChar = hexChar(fieldA[15:12]);
      4'h3: txChar = hexChar(fieldA[11:8]);
      4'h4: txChar = hexChar(fieldA[7:4]);
      4'h5: txChar = hexChar(fieldA[3:0]);
      4'h7: txChar = hexChar(fieldB[15:12]);
      4'h8: txChar = hexChar(fieldB[11:8]);
      4'h9: txChar = hexChar(fieldB[7:4]);
      4'ha: txChar = hexChar(fieldB[3:0]);
      4'hb: txChar = CHAR_CR;
      default: txChar = CHAR_LF;
    endcase
  end
  assign txBusy = (txState != TX_IDLE);
  assign txStart = (txState == TX_SEND) && txReady;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      txState <= TX_IDLE;
      recIdx <= 5'h00;
      charIdx <= 4'h0;
    end else begin
      case (txState)
        TX_IDLE: if (cmdFire) begin
          txState <= TX_SEND;
          recIdx <= 5'h00;
          charIdx <= 4'h0;
        end
        TX_SEND: if (txReady) txState <= TX_WAIT;
        TX_WAIT: if (!txReady) begin
          txState <= TX_SEND;
          if (charIdx == 4'hc) begin
            charIdx <= 4'h0;
            if (recIdx == recLast) txState <= TX_IDLE;
            else recIdx <= recIdx + 5'h01;
          end else charIdx <= charIdx + 4'h1;
        end
        default: txState <= TX_IDLE;
      endcase
    end
  end

  uart_tx_serial #(.BAUD_CYCLES(BAUD_CYCLES)) txUnit (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(txStart),
    .data(txChar),
    .ready(txReady),
    .txd(txd)
  );
endmodule
`default_nettype wire

// file: tb/svc_term_asserts.sv
// Port checker for the service terminal block.
// Assumes it is bound onto the top module, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module svc_term_asserts
  import svc_term_pkg::*;
#(
  parameter int MINUTE_CYCLES = 100, // Cycles per minute
  parameter int BAUD_CYCLES = BIT_CYCLES // Cycles per serial bit
)(
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset
  input wire logic txd, // Serial out
  input wire logic configMode2, // Mode select
  input wire logic remoteClear, // Remote clear
  input wire logic upButton, // Up arrow
  input wire logic downButton, // Down arrow
  input wire logic [NUM_FAULTS-1:0] faultIn, // Fault pulses
  input wire logic heliumCool, // Below cut-off
  input wire logic [NUM_FAULTS-1:0] faultLatched, // Sticky faults
  input wire logic compressorOn // Run command
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  localparam int HALF_BAUD = BAUD_CYCLES / 2; // Mid-bit point
  longint heAge; // Cycles the helium fault has stood
  int clrAge; // Cycles since an allowed clear
  int frameCnt; // Position inside an output frame
  logic prevTxd; // Line one cycle ago
  // Age of the last clear that the mode allows
  always_ff @(posedge clk) begin
    if (sys_rst || remoteClear || (!configMode2 && upButton && downButton)) begin
      clrAge <= 0;
    end else if (clrAge < 100) begin
      clrAge <= clrAge + 1;
    end
  end
  // Age of the standing helium fault, for automatic restarts
  always_ff @(posedge clk) begin
    if (sys_rst || !faultLatched[0]) begin
      heAge <= 0;
    end else begin
      heAge <= heAge + 1;
    end
  end
  // Follow each frame from its falling start edge
  always_ff @(posedge clk) begin
    prevTxd <= txd;
    if (sys_rst) begin
      frameCnt <= 0;
    end else if (frameCnt == 0) begin
      frameCnt <= (prevTxd && !txd) ? 1 : 0;
    end else begin
      frameCnt <= (frameCnt >= 10 * BAUD_CYCLES - HALF_BAUD) ? 0 : frameCnt + 1;
    end
  end
  AST_RESET_STATE: assert property (disable iff (1'b0)
    sys_rst |=> txd && faultLatched == '0 && !compressorOn) else $error("reset state wrong");
  AST_IDLE_AFTER_RESET: assert property ($fell(sys_rst) |-> txd [*8])
    else $error("line not idle after reset");
  AST_FAULT_CAPTURE: assert property (|faultIn |-> ##[1:4] |faultLatched)
    else $error("fault not latched");
  AST_CLEAR_CAUSE: assert property (|($past(faultLatched) & ~faultLatched) |->
    clrAge < 8 || (($past(faultLatched) & ~faultLatched) == NUM_FAULTS'(1) &&
    heAge >= longint'(RESTART_MIN) * MINUTE_CYCLES))
    else $error("fault cleared without allowed cause");
  AST_SHUTDOWN_OFF: assert property ($rose(faultLatched[0]) |-> ##[0:2] !compressorOn)
    else $error("still running after over-temp");
  AST_RESTART_COOL: assert property ($rose(compressorOn) |-> $past(heliumCool))
    else $error("restart while hot");
  AST_START_BIT: assert property (frameCnt == HALF_BAUD |-> !txd)
    else $error("start bit too short");
  AST_STOP_BIT: assert property (frameCnt == 9 * BAUD_CYCLES + HALF_BAUD |-> txd)
    else $error("stop bit missing");
endmodule
bind compressor_service_terminal svc_term_asserts #(.MINUTE_CYCLES(MINUTE_CYCLES),
  .BAUD_CYCLES(BAUD_CYCLES)) chk (
  .clk(clk), .sys_rst(sys_rst), .txd(txd), .configMode2(configMode2),
  .remoteClear(remoteClear), .upButton(upButton), .downButton(downButton),
  .faultIn(faultIn), .heliumCool(heliumCool), .faultLatched(faultLatched),
  .compressorOn(compressorOn));
`default_nettype wire

// file: tb/host_terminal.sv
// Terminal emulator model on the far side of the serial link.
// Assumes the shared clock for bit timing; line idles high.
`timescale 1ns/1ps
`default_nettype none
module host_terminal
  import svc_term_pkg::*;
#(
  parameter int BAUD_CYCLES = BIT_CYCLES // Cycles per serial bit
)(
  input wire logic clk, // System clock
  output logic rxd, // Line into the device
  input wire logic txd // Line from the device
);
  logic [7:0] rxQ[$]; // Characters received
  logic [7:0] sh; // Receive shift register
  initial rxd = 1'b1;
  // One 8N1 frame, low bit first, no flow control
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= frame[i];
      repeat (BAUD_CYCLES) @(posedge clk);
    end
  endtask
  // Receiver sampling each bit mid-way
  initial begin
    forever begin
      @(negedge txd);
      repeat (BAUD_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_CYCLES) @(posedge clk);
        sh[i] = txd;
      end
      repeat (BAUD_CYCLES) @(posedge clk);
      rxQ.push_back(sh);
    end
  end
endmodule
`default_nettype wire

// file: tb/compressor_service_terminal_tb.sv
// Self-checking bench for the service terminal block.
// Assumes the host model drives rxd; short minute parameter.
`timescale 1ns/1ps
`default_nettype none
module compressor_service_terminal_tb
  import svc_term_pkg::*;
;
  localparam int MINS = 100; // Short minute
  localparam int BAUD = 12; // Short bit time keeps the run brief
  localparam int WATCHDOG = 90000; // Tests need about 70k cycles
  logic clk = 1'b0, sys_rst = 1'b1, configMode2 = 1'b0, remoteClear = 1'b0;
  logic upButton = 1'b0, downButton = 1'b0, onButton = 1'b0, heliumCool = 1'b1;
  logic hourTick = 1'b0; // Run hour pulse
  logic [NUM_FAULTS-1:0] faultIn = '0, faultLatched, f;
  logic [15:0] pBar = '0, pPsig = '0, tHel = '0, tWat = '0;
  logic rxd, txd, compressorOn; // Link and run command
  int failures = 0, samples_checked = 0;
  always #20 clk = ~clk;
  compressor_service_terminal #(.MINUTE_CYCLES(MINS), .BAUD_CYCLES(BAUD)) dut (
    .clk(clk), .sys_rst(sys_rst), .rxd(rxd), .txd(txd), .configMode2(configMode2),
    .remoteClear(remoteClear), .upButton(upButton), .downButton(downButton),
    .onButton(onButton), .faultIn(faultIn), .heliumCool(heliumCool),
    .returnPressBar(pBar), .returnPressPsig(pPsig), .heliumTemp(tHel),
    .waterTemp(tWat), .hourTick(hourTick), .faultLatched(faultLatched),
    .compressorOn(compressorOn));
  host_terminal #(.BAUD_CYCLES(BAUD)) host (.clk(clk), .rxd(rxd), .txd(txd));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Counts: %0d compared, %0d wrong", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Expected reply line
  function automatic string reply(input logic [7:0] t, input logic [15:0] a, input logic [15:0] b);
    return $sformatf("%c %h %h%c%c", t, a, b, CHAR_CR, CHAR_LF);
  endfunction
  // Expected history dump: one record, then empty slots
  function automatic string hist_reply(input logic [2:0] code);
    string s;
    s = reply("h", {8'h01, 5'h00, code}, 16'h0000);
    for (int k = 1; k < HIST_DEPTH; k++) begin
      s = {s, reply("h", 16'h0000, 16'h0000)};
    end
    return s;
  endfunction
  // Letter plus line end, then compare the whole reply
  task automatic command(input logic [7:0] ch, input string exp);
    int n;
    host.rxQ.delete();
    host.send_char(ch);
    host.send_char(CHAR_CR);
    if (exp.len() == 0) begin
      repeat (130 * BAUD) @(posedge clk);
    end
    n = 0;
    while (host.rxQ.size() < exp.len() && n < 400000) begin
      @(posedge clk);
      n++;
    end
    check(16'(host.rxQ.size()), 16'(exp.len()), "reply length");
    for (int i = 0; i < exp.len(); i++) begin
      check({8'h00, host.rxQ[i]}, {8'h00, exp[i]}, "reply char");
    end
    $display("command %c done", ch);
  endtask
  // Hold a set of async inputs, then release
  task automatic buttons(input logic r, input logic u, input logic d, input logic o);
    @(posedge clk);
    remoteClear <= r;
    upButton <= u;
    downButton <= d;
    onButton <= o;
    repeat (6) @(posedge clk);
    remoteClear <= 1'b0;
    upButton <= 1'b0;
    downButton <= 1'b0;
    onButton <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
  // One-cycle fault pulse
  task automatic trip(input logic [NUM_FAULTS-1:0] v);
    @(posedge clk);
    faultIn <= v;
    @(posedge clk);
    faultIn <= '0;
    repeat (6) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    void'($urandom(75));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    check({7'h00, txd, compressorOn, faultLatched}, 16'h0100, "reset state");
    pBar <= 16'($urandom());
    pPsig <= 16'($urandom());
    tHel <= 16'($urandom());
    tWat <= 16'($urandom());
    @(posedge clk);
    command("a", reply("a", 16'(FW_VERSION), 16'h0000));
    command("M", reply("m", 16'(CHAR_I), 16'h0000));
    command("D", reply("d", pBar, pPsig));
    command("e", reply("e", tHel, tWat));
    command("c", reply("c", 16'h0000, 16'h0000));
    command("g", reply("g", ADS_LIFE_NEW, 16'h0000));
    command("F", reply("f", ADS_LIFE_NEW, 16'h0000));
    command("x", "");
    configMode2 <= 1'b1;
    f = (7'($urandom()) | 7'h02) & 7'h7e;
    trip(f);
    command("b", reply("b", 16'h0001, {9'h000, f}));
    // Bit 1 of f is always set and bit 0 never, so code 1 is logged
    command("h", hist_reply(3'h1));
    buttons(1'b0, 1'b1, 1'b1, 1'b0);
    check(16'(faultLatched), 16'(f), "arrows clear in mode 2");
    buttons(1'b1, 1'b0, 1'b0, 1'b0);
    check(16'(faultLatched), 16'h0000, "remote clear");
    configMode2 <= 1'b0;
    trip(f);
    buttons(1'b0, 1'b1, 1'b1, 1'b0);
    check(16'(faultLatched), 16'h0000, "arrows clear in mode 1");
    $display("clearing done");
    buttons(1'b0, 1'b0, 1'b0, 1'b1);
    check(16'(compressorOn), 16'h0001, "on press");
    heliumCool <= 1'b0;
    trip(7'h01);
    check(16'(compressorOn), 16'h0000, "over-temp shutdown");
    buttons(1'b0, 1'b0, 1'b0, 1'b1);
    check(16'(compressorOn), 16'h0000, "on while latched");
    buttons(1'b1, 1'b0, 1'b0, 1'b1);
    check(16'(compressorOn), 16'h0000, "on while hot");
    heliumCool <= 1'b1;
    buttons(1'b0, 1'b0, 1'b0, 1'b1);
    check(16'(compressorOn), 16'h0001, "on when cool");
    // Three run hours while running
    repeat (3) begin
      @(posedge clk);
      hourTick <= 1'b1;
      @(posedge clk);
      hourTick <= 1'b0;
    end
    command("c", reply("c", 16'h0003, 16'h0003));
    command("f", reply("f", ADS_LIFE_NEW - 16'h0003, 16'h0000));
    command("g", reply("g", ADS_LIFE_NEW, 16'h0000));
    $display("restart done");
    configMode2 <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      trip(7'h01);
      repeat (19 * MINS - 20) @(posedge clk);
      check(16'(compressorOn), 16'h0000, "restart inside lockout");
      repeat (MINS + 40) @(posedge clk);
      check(16'(compressorOn), (i < 5) ? 16'h0001 : 16'h0000, "auto restart");
    end
    buttons(1'b1, 1'b0, 1'b0, 1'b1);
    trip(7'h01);
    repeat (20 * MINS + 40) @(posedge clk);
    check(16'(compressorOn), 16'h0001, "counter zeroed by reset");
    $display("auto restart done");
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (WATCHDOG) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
